// File: rtl/sse_exec.sv
// Execution core for increment-skip, nonzero skips and subtract operations
// ----------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------
module sse_exec
  import sse_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic op_valid,
  input wire sse_pkg::sse_op_e op_code,
  input wire logic [sse_pkg::DATA_W-1:0] mem_rd_data,
  input wire logic [sse_pkg::BIT_SEL_W-1:0] bit_sel,
  output logic op_ready,
  output logic op_done,
  output logic skip_pulse,
  output logic [sse_pkg::DATA_W-1:0] accumulator,
  output logic mem_wr_en,
  output logic [sse_pkg::DATA_W-1:0] mem_wr_data,
  output logic overflow_flag,
  output logic zero_flag,
  output logic aux_carry_flag,
  output logic carry_flag,
  output logic signed_compare_flag,
  output logic combined_zero_flag
);
  import sse_pkg::*;

  // ----------------------------------------------------------------
  // Arithmetic and skip units
  // ----------------------------------------------------------------
  sse_alu_if alu ();

  sse_sub_unit u_sub (
    .alu(alu.sub)
  );

  sse_skip_unit u_skip (
    .alu(alu.skip)
  );

  sse_state_e state_reg;
  sse_state_e state_next;
  logic [DATA_W-1:0] accumulator_reg;
  logic [DATA_W-1:0] accumulator_next;
  sse_flags_s flags_reg;
  sse_flags_s flags_next;
  logic mem_wr_en_reg;
  logic mem_wr_en_next;
  logic [DATA_W-1:0] mem_wr_data_reg;
  logic [DATA_W-1:0] mem_wr_data_next;
  logic skip_pulse_reg;
  logic skip_pulse_next;
  logic op_done_reg;
  logic op_done_next;
  logic op_ready_reg;
  logic op_ready_next;
  logic take;
  logic skip_cond;

  assign alu.acc = accumulator_reg;
  assign alu.mem = mem_rd_data;
  assign alu.bit_sel = bit_sel;

  // An instruction offered during the dummy cycle is the skipped one and is dropped
  assign take = op_valid && (state_reg == SSE_ST_EXEC);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = SSE_ST_EXEC;
    accumulator_next = accumulator_reg;
    flags_next = flags_reg;
    mem_wr_en_next = 1'b0;
    mem_wr_data_next = mem_wr_data_reg;
    skip_pulse_next = 1'b0;
    op_done_next = 1'b0;
    op_ready_next = 1'b1;
    skip_cond = 1'b0;
    case (state_reg)
      SSE_ST_DUMMY: begin
        state_next = SSE_ST_EXEC;
      end
      SSE_ST_EXEC: begin
        if (take) begin
          op_done_next = 1'b1;
          case (op_code)
            SSE_OP_INC_SKIP_ZERO_TO_ACC: begin
              accumulator_next = alu.inc_sum;
              skip_cond = alu.inc_zero;
            end
            SSE_OP_SKIP_BIT_NONZERO: begin
              skip_cond = alu.bit_hit;
            end
            SSE_OP_SKIP_IF_NONZERO: begin
              mem_wr_en_next = 1'b1;
              mem_wr_data_next = mem_rd_data;
              skip_cond = alu.byte_nonzero;
            end
            SSE_OP_SUB_TO_ACC: begin
              accumulator_next = alu.diff;
              flags_next = alu.sub_flags;
            end
            SSE_OP_SUBTRACT_TO_MEM: begin
              mem_wr_en_next = 1'b1;
              mem_wr_data_next = alu.diff;
              flags_next = alu.sub_flags;
            end
            default: begin
              op_done_next = 1'b1;
            end
          endcase
          if (skip_cond) begin
            state_next = SSE_ST_DUMMY;
            skip_pulse_next = 1'b1;
            op_ready_next = 1'b0;
          end
        end
      end
      default: begin
        state_next = SSE_ST_EXEC;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= SSE_ST_EXEC;
      accumulator_reg <= ACC_RESET;
      flags_reg <= FLAGS_RESET;
      mem_wr_en_reg <= 1'b0;
      mem_wr_data_reg <= MEM_WR_DATA_RESET;
      skip_pulse_reg <= 1'b0;
      op_done_reg <= 1'b0;
      op_ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      accumulator_reg <= accumulator_next;
      flags_reg <= flags_next;
      mem_wr_en_reg <= mem_wr_en_next;
      mem_wr_data_reg <= mem_wr_data_next;
      skip_pulse_reg <= skip_pulse_next;
      op_done_reg <= op_done_next;
      op_ready_reg <= op_ready_next;
    end
  end

  assign op_ready = op_ready_reg;
  assign op_done = op_done_reg;
  assign skip_pulse = skip_pulse_reg;
  assign accumulator = accumulator_reg;
  assign mem_wr_en = mem_wr_en_reg;
  assign mem_wr_data = mem_wr_data_reg;
  assign overflow_flag = flags_reg.overflow_flag;
  assign zero_flag = flags_reg.zero_flag;
  assign aux_carry_flag = flags_reg.aux_carry_flag;
  assign carry_flag = flags_reg.carry_flag;
  assign signed_compare_flag = flags_reg.signed_compare_flag;
  assign combined_zero_flag = flags_reg.combined_zero_flag;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic is_inc;
  logic is_bit;
  logic is_byte;
  logic is_sub;
  logic is_subtract_to_mem;
  logic mem_all_ones;
  logic sel_bit;
  assign is_inc = take && (op_code == SSE_OP_INC_SKIP_ZERO_TO_ACC);
  assign is_bit = take && (op_code == SSE_OP_SKIP_BIT_NONZERO);
  assign is_byte = take && (op_code == SSE_OP_SKIP_IF_NONZERO);
  assign is_sub = take && (op_code == SSE_OP_SUB_TO_ACC);
  assign is_subtract_to_mem = take && (op_code == SSE_OP_SUBTRACT_TO_MEM);
  assign mem_all_ones = &mem_rd_data;
  assign sel_bit = mem_rd_data[bit_sel];
  logic acc_sign;
  logic mem_sign;
  logic [NIBBLE_W-1:0] acc_low;
  logic [NIBBLE_W-1:0] mem_low;
  assign acc_sign = accumulator_reg[DATA_W-1];
  assign mem_sign = mem_rd_data[DATA_W-1];
  assign acc_low = accumulator_reg[NIBBLE_W-1:0];
  assign mem_low = mem_rd_data[NIBBLE_W-1:0];

  // The skipping instruction still reports done; only ready drops
  sequence s_dummy_slot;
    !op_ready_reg && op_done_reg;
  endsequence

  sequence s_back_to_exec;
    op_ready_reg && !op_done_reg && !skip_pulse_reg && !mem_wr_en_reg;
  endsequence

  chk_inc_to_acc: assert property (
    is_inc |=> (accumulator_reg == 8'($past(mem_rd_data) + INC_STEP)) && !mem_wr_en_reg)
    else $error("increment result not placed in accumulator");

  chk_inc_skip_zero: assert property (
    is_inc |=> (skip_pulse_reg == $past(mem_all_ones)))
    else $error("increment skip decision wrong");

  chk_skip_dummy_len: assert property (
    skip_pulse_reg |-> s_dummy_slot ##1 s_back_to_exec)
    else $error("skip did not take exactly one dummy cycle");

  chk_noskip_continue: assert property (
    take && !skip_pulse_next |=> op_ready_reg && op_done_reg && !skip_pulse_reg)
    else $error("untaken skip stalled the next instruction");

  chk_skip_flags_kept: assert property (
    is_inc || is_bit || is_byte |=> $stable(flags_reg))
    else $error("skip operation changed a flag");

  chk_bit_test: assert property (
    is_bit |=> skip_pulse_reg == $past(sel_bit))
    else $error("bit test skip decision wrong");

  chk_byte_writeback: assert property (
    is_byte |=> mem_wr_en_reg && (mem_wr_data_reg == $past(mem_rd_data)))
    else $error("byte test did not write the value back");

  chk_byte_skip: assert property (
    is_byte |=> skip_pulse_reg == ($past(mem_rd_data) != ZERO_BYTE))
    else $error("byte test skip decision wrong");

  chk_sub_acc: assert property (
    is_sub |=> accumulator_reg == 8'($past(accumulator_reg) - $past(mem_rd_data)))
    else $error("subtract result wrong in accumulator");

  chk_sub_carry: assert property (
    is_sub |=> carry_flag == ($past(accumulator_reg) >= $past(mem_rd_data)))
    else $error("subtract carry wrong");

  chk_sub_zero_flags: assert property (
    is_sub |=> zero_flag == (accumulator_reg == ZERO_BYTE) && combined_zero_flag == zero_flag)
    else $error("subtract zero flags wrong");

  chk_sub_overflow: assert property (
    is_sub |=> overflow_flag == (($past(acc_sign) != $past(mem_sign)) && (acc_sign != $past(acc_sign))))
    else $error("subtract overflow wrong");

  chk_sub_aux_carry: assert property (
    is_sub |=> aux_carry_flag == ($past(acc_low) >= $past(mem_low)))
    else $error("subtract auxiliary carry wrong");

  chk_sub_signed_cmp: assert property (
    is_sub |=> signed_compare_flag == (overflow_flag ^ acc_sign))
    else $error("subtract signed compare wrong");

  chk_subtract_to_mem_mem: assert property (
    is_subtract_to_mem |=> mem_wr_en_reg && $stable(accumulator_reg) &&
                mem_wr_data_reg == 8'($past(accumulator_reg) - $past(mem_rd_data)))
    else $error("subtract to memory result wrong");

  chk_subtract_to_mem_carry: assert property (
    is_subtract_to_mem |=> carry_flag == ($past(accumulator_reg) >= $past(mem_rd_data)))
    else $error("subtract to memory carry wrong");

  chk_subtract_to_mem_flags: assert property (
    is_subtract_to_mem |=> zero_flag == (mem_wr_data_reg == ZERO_BYTE) &&
                signed_compare_flag == (overflow_flag ^ mem_wr_data_reg[DATA_W-1]))
    else $error("subtract to memory flags wrong");

  chk_dummy_idle: assert property (
    skip_pulse_reg |=> $stable(accumulator_reg) && $stable(flags_reg) && !mem_wr_en_reg)
    else $error("dummy cycle changed state");

endmodule // sse_exec

// File: rtl/sse_pkg.sv
// Shared constants and types for the skip and subtract execution block
package sse_pkg;

  // ----------------------------------------------------------------
  // Widths, reset values and constants
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int BIT_SEL_W = 3;
  localparam int NIBBLE_W = 4;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] MEM_WR_DATA_RESET = 8'h00;
  localparam logic [7:0] INC_STEP = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Operations and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSE_OP_NOP,
    SSE_OP_INC_SKIP_ZERO_TO_ACC,
    SSE_OP_SKIP_BIT_NONZERO,
    SSE_OP_SKIP_IF_NONZERO,
    SSE_OP_SUB_TO_ACC,
    SSE_OP_SUBTRACT_TO_MEM
  } sse_op_e;

  typedef enum logic {
    SSE_ST_EXEC,
    SSE_ST_DUMMY
  } sse_state_e;

  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
    logic signed_compare_flag;
    logic combined_zero_flag;
  } sse_flags_s;

  localparam sse_flags_s FLAGS_RESET = '{default: 1'b0};

endpackage : sse_pkg

// File: rtl/sse_alu_if.sv
// Operand and result bundle between the execution core and its two units
interface sse_alu_if;
  import sse_pkg::*;

  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] mem;
  logic [BIT_SEL_W-1:0] bit_sel;
  logic [DATA_W-1:0] diff;
  sse_flags_s sub_flags;
  logic [DATA_W-1:0] inc_sum;
  logic inc_zero;
  logic bit_hit;
  logic byte_nonzero;

  modport core (output acc, output mem, output bit_sel, input diff, input sub_flags,
                input inc_sum, input inc_zero, input bit_hit, input byte_nonzero);
  modport sub (input acc, input mem, output diff, output sub_flags);
  modport skip (input mem, input bit_sel, output inc_sum, output inc_zero, output bit_hit,
                output byte_nonzero);
endinterface : sse_alu_if

// File: rtl/sse_sub_unit.sv
// Subtractor: accumulator minus memory byte with the six status flags
module sse_sub_unit
  import sse_pkg::*;
(
  sse_alu_if.sub alu
);

  logic [DATA_W:0] wide_diff;
  logic [NIBBLE_W:0] low_diff;

  always_comb begin
    wide_diff = {1'b0, alu.acc} - {1'b0, alu.mem};
    low_diff = {1'b0, alu.acc[NIBBLE_W-1:0]} - {1'b0, alu.mem[NIBBLE_W-1:0]};
    alu.diff = wide_diff[DATA_W-1:0];
    // Carry is the inverse of borrow: set when the difference is zero or positive
    alu.sub_flags.carry_flag = ~wide_diff[DATA_W];
    alu.sub_flags.aux_carry_flag = ~low_diff[NIBBLE_W];
    alu.sub_flags.zero_flag = (wide_diff[DATA_W-1:0] == ZERO_BYTE);
    alu.sub_flags.overflow_flag = (alu.acc[DATA_W-1] ^ alu.mem[DATA_W-1]) &
                                  (alu.acc[DATA_W-1] ^ wide_diff[DATA_W-1]);
    alu.sub_flags.signed_compare_flag = alu.sub_flags.overflow_flag ^ wide_diff[DATA_W-1];
    // Single byte operation, so the combined zero follows the plain zero
    alu.sub_flags.combined_zero_flag = alu.sub_flags.zero_flag;
  end

endmodule // sse_sub_unit

// File: rtl/sse_skip_unit.sv
// Skip condition evaluation for the three conditional skip operations
module sse_skip_unit
  import sse_pkg::*;
(
  sse_alu_if.skip alu
);

  always_comb begin
    alu.inc_sum = alu.mem + INC_STEP;
    alu.inc_zero = (alu.inc_sum == ZERO_BYTE);
    alu.bit_hit = alu.mem[alu.bit_sel];
    alu.byte_nonzero = (alu.mem != ZERO_BYTE);
  end

endmodule // sse_skip_unit

// File: test/sse_exec_tb.sv
// Self-checking bench for the skip and subtract execution core
module sse_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sse_pkg::*;

  logic clk;
  logic reset;
  logic op_valid;
  sse_op_e op_code;
  logic [7:0] mem_rd_data;
  logic [2:0] bit_sel;
  logic op_ready, op_done, skip_pulse, mem_wr_en;
  logic [7:0] accumulator, mem_wr_data;
  wire [5:0] flags;
  int miscompares, total_checks, cycles;
  int m_acc, m_wrd;
  logic [5:0] m_flags;
  logic m_ready;
  logic [7:0] pairs [12] = '{8'h00, 8'h01, 8'h80, 8'h01, 8'h7f, 8'hff, 8'h10, 8'h01, 8'h55, 8'h55, 8'hff, 8'h00};

  sse_exec sse_exec_inst (
    .clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code), .mem_rd_data(mem_rd_data),
    .bit_sel(bit_sel), .op_ready(op_ready), .op_done(op_done), .skip_pulse(skip_pulse),
    .accumulator(accumulator), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
    .overflow_flag(flags[5]), .zero_flag(flags[4]), .aux_carry_flag(flags[3]), .carry_flag(flags[2]),
    .signed_compare_flag(flags[1]), .combined_zero_flag(flags[0])
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk_bit(input string what, input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s is %b, expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s is %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Reference model and stimulus
  // ----------------------------------------------------------------
  function automatic void model_sub(input int a, input int m, output int d, output logic [5:0] f);
    logic ov, z;
    d = (a - m) & 255;
    ov = (a[7] != m[7]) && (d[7] != a[7]);
    z = (d == 0);
    f = {ov, z, a[3:0] >= m[3:0], a >= m, ov ^ d[7], z};
  endfunction

  task automatic do_reset(input int n);
    reset = 1'b1;
    op_valid = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    reset = 1'b0;
    m_acc = 0;
    m_wrd = 0;
    m_flags = '0;
    m_ready = 1'b1;
  endtask

  // Drives one cycle, then compares every output one edge later
  task automatic step(input sse_op_e op, input logic v, input logic [7:0] m, input logic [2:0] b);
    logic taken, e_skip, e_wr;
    int d;
    logic [5:0] f;
    op_valid = v;
    op_code = op;
    mem_rd_data = m;
    bit_sel = b;
    taken = v && m_ready;
    e_skip = 1'b0;
    e_wr = 1'b0;
    if (taken) begin
      case (op)
        SSE_OP_INC_SKIP_ZERO_TO_ACC: begin
          m_acc = (m + 1) & 255;
          e_skip = (m_acc == 0);
        end
        SSE_OP_SKIP_BIT_NONZERO: e_skip = m[b];
        SSE_OP_SKIP_IF_NONZERO: begin
          e_skip = (m != 8'h00);
          e_wr = 1'b1;
          m_wrd = m;
        end
        SSE_OP_SUB_TO_ACC: begin
          model_sub(m_acc, m, d, f);
          m_acc = d;
          m_flags = f;
        end
        SSE_OP_SUBTRACT_TO_MEM: begin
          model_sub(m_acc, m, d, f);
          m_wrd = d;
          e_wr = 1'b1;
          m_flags = f;
        end
        default: ;
      endcase
    end
    m_ready = !e_skip;
    @(posedge clk);
    #1;
    chk_bit("op_done", op_done, taken);
    chk_bit("op_ready", op_ready, m_ready);
    chk_bit("skip_pulse", skip_pulse, e_skip);
    chk_bit("mem_wr_en", mem_wr_en, e_wr);
    chk_byte("accumulator", accumulator, 8'(m_acc));
    chk_byte("mem_wr_data", mem_wr_data, 8'(m_wrd));
    chk_byte("flags", {2'b00, flags}, {2'b00, m_flags});
  endtask

  // A zero load skips, so a spare cycle covers the dummy slot
  task automatic load_acc(input logic [7:0] x);
    step(SSE_OP_INC_SKIP_ZERO_TO_ACC, 1'b1, x - 8'h01, 3'h0);
    if (x == 8'h00) step(SSE_OP_NOP, 1'b0, 8'h00, 3'h0);
  endtask

  initial begin
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    reset = 1'b1;
    op_valid = 1'b0;
    op_code = SSE_OP_NOP;
    mem_rd_data = 8'h00;
    bit_sel = 3'h0;
    void'($urandom(32'h98d2));
    do_reset(12);
    step(SSE_OP_NOP, 1'b0, 8'h00, 3'h0);
    $display("Test reset done");
    for (int i = 0; i < 12; i += 2) begin
      load_acc(pairs[i]);
      step(SSE_OP_SUB_TO_ACC, 1'b1, pairs[i+1], 3'h0);
      load_acc(pairs[i]);
      step(SSE_OP_SUBTRACT_TO_MEM, 1'b1, pairs[i+1], 3'h0);
    end
    $display("Test subtract done");
    step(SSE_OP_INC_SKIP_ZERO_TO_ACC, 1'b1, 8'hff, 3'h0);
    step(SSE_OP_SUB_TO_ACC, 1'b1, 8'h33, 3'h0);
    step(SSE_OP_INC_SKIP_ZERO_TO_ACC, 1'b1, 8'h05, 3'h0);
    step(SSE_OP_SUB_TO_ACC, 1'b1, 8'h01, 3'h0);
    $display("Test increment skip done");
    for (int i = 0; i < 8; i++) begin
      step(SSE_OP_SKIP_BIT_NONZERO, 1'b1, 8'h01 << i, 3'(i));
      step(SSE_OP_SUBTRACT_TO_MEM, 1'b1, 8'h11, 3'h0);
      step(SSE_OP_SKIP_BIT_NONZERO, 1'b1, ~(8'h01 << i), 3'(i));
    end
    $display("Test bit skip done");
    step(SSE_OP_SKIP_IF_NONZERO, 1'b1, 8'h00, 3'h0);
    step(SSE_OP_SKIP_IF_NONZERO, 1'b1, 8'h80, 3'h0);
    step(SSE_OP_SKIP_IF_NONZERO, 1'b1, 8'h00, 3'h0);
    step(SSE_OP_SKIP_IF_NONZERO, 1'b1, 8'h01, 3'h0);
    do_reset(2);
    step(SSE_OP_NOP, 1'b0, 8'h00, 3'h0);
    $display("Test byte skip and reset done");
    repeat (300) begin
      step(sse_op_e'($urandom % 6), ($urandom % 4) != 0, 8'($urandom), 3'($urandom));
    end
    $display("Test random mix done");
    results();
  end
endmodule // sse_exec_tb
